// ===== design/pmic_fault_status_serial_port.sv
// serial control port with fault latching, alert and hard shutdown
// Operation
// - status bit4 undervoltage warning, bit6 thermal warning
// - fault latches alert low, sets bit 3/5/7
// - warning holds until clear and condition gone
// - fault alert holds until clear command
// - fault bit holds after clear for condition time plus inhibit
// - fault forces shutdown, clears enable register
// - fault: power down until one second after the fault goes, then off
// - re-enable blocked until fault gone and timeout
// - then power_on_request raises wake, pins obeyed
// - interface supply lockout resets everything
// - works to 400 kHz, glitch filters
// - eight bits MSB first plus acknowledge
// - acknowledge address, sub-address, data; SDA released in the read byte's ack slot
// - device holds SDA low through ack clock
// - write address 0x68, read address 0x69
// - write is sub-address then data, repeatable
// - data into holding latch at its acknowledge
// - holding latches commit only on stop
// - read returns addressed register eight bits
// - read pointer kept until new sub-address
// - reads before stop return holding latches
// - software bit overrides pins, else ORed
// - power good low 14 ms faults unless masked
module pmic_fault_status_serial_port
  import pmic_port_pkg::*;
#(
  parameter int INHIBIT_CNT = INHIBIT_CYCLES,
  parameter int PG_CNT      = PG_TIMEOUT_CYCLES
) (
  // clock, reset (reset_n driven by interface-supply lockout), enable
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  // serial bus
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // monitor conditions
  input  wire logic       uv_warn_in,
  input  wire logic       uv_fault_in,
  input  wire logic       therm_warn_in,
  input  wire logic       therm_fault_in,
  input  wire logic       power_good_in,
  input  wire logic       power_on_request,
  input  wire logic [6:0] enable_pins,
  // outputs
  output logic            alert_n,
  output logic            system_wake_out,
  output logic [6:0]      regulator_enable,
  output logic [7:0]      fault_event_status,
  output logic [1:0]      pb_state
);
  localparam int CW = 32;
  typedef struct packed {
    logic [1:0]  scl_sync;
    logic [1:0]  sda_sync;
    logic [3:0]  scl_cnt;
    logic [3:0]  sda_cnt;
    logic        scl_f;
    logic        sda_f;
    bus_state_t  bus;
    logic [3:0]  bit_cnt;
    logic [7:0]  shift;
    logic        ack;
    logic        wrote;
    logic [7:0]  ptr;
    logic [7:0]  rd_byte;
    logic        sda_low;
    logic [NUM_CMD_REGS*8-1:0] hold;
    logic [NUM_CMD_REGS*8-1:0] cmd;
    logic        clear_pend;
    logic [7:0]  status;
    logic        alert;
    logic        fault_act;
    pb_state_t   pb;
    logic [CW-1:0] inh_cnt;
    logic [CW-1:0] pg_cnt;
    logic        pg_tripped;
    logic        wake;
    logic [6:0]  reg_en;
  } state_t;
  state_t q, d;

  function automatic int sub_index(input logic [7:0] sub);
    int r;
    r = -1;
    for (int i = 0; i < NUM_CMD_REGS; i++) begin
      if (SUB_TABLE[i] == sub) begin
        r = i;
      end
    end
    return r;
  endfunction

  logic scl_rise, scl_fall, start_c, stop_c;
  logic [7:0] new_byte, regulator_enable_reg;
  int idx;
  logic fault_now;

  always_comb begin
    d = q;
    idx = 0;
    new_byte = 8'h00;
    // two-flop sync then a counting filter rejects short glitches
    d.scl_sync = {q.scl_sync[0], scl_in};
    d.sda_sync = {q.sda_sync[0], sda_in};
    if (q.scl_sync[1] == q.scl_f) begin
      d.scl_cnt = 4'h0;
    end else if (q.scl_cnt == 4'(FILTER_CYCLES - 1)) begin
      d.scl_f = q.scl_sync[1];
      d.scl_cnt = 4'h0;
    end else begin
      d.scl_cnt = q.scl_cnt + 4'h1;
    end
    if (q.sda_sync[1] == q.sda_f) begin
      d.sda_cnt = 4'h0;
    end else if (q.sda_cnt == 4'(FILTER_CYCLES - 1)) begin
      d.sda_f = q.sda_sync[1];
      d.sda_cnt = 4'h0;
    end else begin
      d.sda_cnt = q.sda_cnt + 4'h1;
    end
    scl_rise = d.scl_f & ~q.scl_f;
    scl_fall = ~d.scl_f & q.scl_f;
    start_c = q.scl_f & d.scl_f & q.sda_f & ~d.sda_f;
    stop_c = q.scl_f & d.scl_f & ~q.sda_f & d.sda_f;
    // serial protocol
    if (start_c) begin
      d.bus = BUS_ADDR;
      // the scl fall that closes the start wraps this to zero before bit 7
      d.bit_cnt = 4'hf;
      d.ack = 1'b0;
      d.sda_low = 1'b0;
    end else if (stop_c) begin
      d.bus = BUS_IDLE;
      d.sda_low = 1'b0;
      if (q.wrote) begin
        d.cmd = q.hold;
        d.wrote = 1'b0;
      end
    end else if (q.bus != BUS_IDLE && q.bus != BUS_IGNORE) begin
      if (scl_rise && !q.ack && q.bus != BUS_READ) begin
        d.shift = {q.shift[6:0], q.sda_f};
      end
      if (scl_fall) begin
        if (q.ack) begin
          d.ack = 1'b0;
          d.bit_cnt = 4'h0;
          d.sda_low = 1'b0;
          if (q.bus == BUS_READ) begin
            d.sda_low = ~q.rd_byte[7];
          end
        end else if (q.bit_cnt == 4'd7) begin
          new_byte = q.shift;
          d.ack = 1'b1;
          d.sda_low = 1'b1;
          unique case (q.bus)
            BUS_ADDR: begin
              if (new_byte[7:1] != DEV_ADDR) begin
                d.bus = BUS_IGNORE;
                d.sda_low = 1'b0;
                d.ack = 1'b0;
              end else if (new_byte[0]) begin
                d.bus = BUS_READ;
                idx = sub_index(q.ptr);
                if (q.ptr == SUB_STATUS) begin
                  d.rd_byte = q.status;
                end else if (idx >= 0) begin
                  d.rd_byte = q.hold[idx*8 +: 8];
                end else begin
                  d.rd_byte = 8'h00;
                end
              end else begin
                d.bus = BUS_SUB;
              end
            end
            BUS_SUB: begin
              d.ptr = new_byte;
              d.bus = BUS_DATA;
              if (new_byte == SUB_CLEAR_ALERT) begin
                d.clear_pend = 1'b1;
              end
            end
            BUS_DATA: begin
              idx = sub_index(q.ptr);
              if (idx >= 0) begin
                d.hold[idx*8 +: 8] = new_byte;
                d.wrote = 1'b1;
              end
              d.bus = BUS_SUB;
            end
            BUS_READ: begin
              d.ack = 1'b0;
              d.sda_low = 1'b0;
            end
            default: d.bus = BUS_IGNORE;
          endcase
        end else begin
          d.bit_cnt = q.bit_cnt + 4'h1;
          if (q.bus == BUS_READ) begin
            d.rd_byte = {q.rd_byte[6:0], 1'b0};
            d.sda_low = ~q.rd_byte[6];
            if (q.bit_cnt == 4'd7) begin
              d.sda_low = 1'b0;
            end
          end
        end
      end
      if (q.bus == BUS_READ && scl_fall && q.bit_cnt == 4'd7 && !q.ack) begin
        d.sda_low = 1'b0;
      end
    end
    // fault and warning events
    regulator_enable_reg = q.cmd[8 +: 8];
    d.pg_cnt = power_good_in ? '0 : (q.pg_cnt == CW'(PG_CNT) ? q.pg_cnt : q.pg_cnt + 1'b1);
    d.pg_tripped = (q.pg_cnt == CW'(PG_CNT)) & ~q.cmd[16 + BIT_PG_MASK];
    fault_now = uv_fault_in | therm_fault_in | q.pg_tripped;
    if (q.clear_pend && !d.wrote) begin
      d.clear_pend = 1'b0;
      d.alert = 1'b0;
      if (!uv_warn_in) d.status[BIT_UV_WARN] = 1'b0;
      if (!therm_warn_in) d.status[BIT_THERM_WARN] = 1'b0;
    end
    // fault bits drop only once cleared, timed out and condition gone
    // power down spans the inhibit time; off or on again means it is over
    if (!q.alert && q.pb != PB_POWER_DOWN && !fault_now) begin
      d.status[BIT_PG_TIMEOUT] = 1'b0;
      d.status[BIT_UV_FAULT] = 1'b0;
      d.status[BIT_THERM_FAULT] = 1'b0;
    end
    // setting wins over clearing
    if (uv_warn_in) d.status[BIT_UV_WARN] = 1'b1;
    if (therm_warn_in) d.status[BIT_THERM_WARN] = 1'b1;
    if (uv_warn_in | therm_warn_in) d.alert = 1'b1;
    if (q.pg_tripped) d.status[BIT_PG_TIMEOUT] = 1'b1;
    if (uv_fault_in) d.status[BIT_UV_FAULT] = 1'b1;
    if (therm_fault_in) d.status[BIT_THERM_FAULT] = 1'b1;
    if (fault_now) begin
      d.alert = 1'b1;
      d.fault_act = 1'b1;
      d.pb = PB_POWER_DOWN;
      d.inh_cnt = '0;
      d.cmd[8 +: 8] = 8'h00;
      d.hold[8 +: 8] = 8'h00;
    end else if (q.pb == PB_POWER_DOWN) begin
      if (q.inh_cnt == CW'(INHIBIT_CNT - 1)) begin
        d.pb = PB_POWER_OFF;
      end else begin
        d.inh_cnt = q.inh_cnt + 1'b1;
      end
    end else if (q.pb == PB_POWER_OFF && power_on_request) begin
      d.pb = PB_ON;
      d.fault_act = 1'b0;
    end
    if (!power_on_request && !q.fault_act) begin
      d.cmd[8 +: 8] = 8'h00;
    end
    // regulator enables
    // next-state view so enables drop in the same edge as the fault latches
    if (d.fault_act || d.pb != PB_ON) begin
      d.reg_en = 7'h00;
      d.wake = 1'b0;
    end else begin
      d.wake = power_on_request;
      d.reg_en = regulator_enable_reg[BIT_SW_CONTROL] ? regulator_enable_reg[6:0] : (regulator_enable_reg[6:0] | enable_pins);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.scl_sync <= 2'h3;
      q.sda_sync <= 2'h3;
      q.scl_f <= 1'b1;
      q.sda_f <= 1'b1;
      q.bus <= BUS_IDLE;
      q.pb <= PB_POWER_OFF;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = q.sda_low;
  assign alert_n = ~q.alert;
  assign system_wake_out = q.wake;
  assign regulator_enable = q.reg_en;
  assign fault_event_status = q.status;
  assign pb_state = q.pb;

  AST_FAULT_ALERT: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && therm_fault_in |=> !alert_n && fault_event_status[BIT_THERM_FAULT])
    else $error("fault did not latch alert");
  AST_SHUTDOWN: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && uv_fault_in |=> ##1 regulator_enable == 7'h00 && !system_wake_out)
    else $error("fault did not shut down");
  AST_WARN: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && uv_warn_in |=> fault_event_status[BIT_UV_WARN])
    else $error("warning not latched");
  AST_ALERT_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    !alert_n && !q.clear_pend |=> !alert_n)
    else $error("alert dropped without clear");
  AST_PB_DOWN: assert property (@(posedge clk) disable iff (!reset_n)
    clk_en && fault_now |=> pb_state == PB_POWER_DOWN)
    else $error("not in power down after fault");
  AST_ACK_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    q.ack && q.bus != BUS_READ && !scl_fall && !start_c && !stop_c |=> sda_oe)
    else $error("ack released early");
  AST_IGNORE: assert property (@(posedge clk) disable iff (!reset_n)
    q.bus == BUS_IGNORE |-> !sda_oe)
    else $error("drove bus while ignoring");
  AST_NO_REENABLE: assert property (@(posedge clk) disable iff (!reset_n)
    pb_state == PB_POWER_DOWN |-> regulator_enable == 7'h00)
    else $error("regulator on during inhibit");
endmodule // pmic_fault_status_serial_port

// ===== design/pmic_port_pkg.sv
// constants for the power-management serial control port
package pmic_port_pkg;
  localparam logic [6:0] DEV_ADDR        = 7'h34;
  localparam int         NUM_CMD_REGS    = 14;
  localparam logic [7:0] SUB_SCR1        = 8'h07;
  localparam logic [7:0] SUB_REGULATOR_ENABLE_REG        = 8'h10;
  localparam logic [7:0] SUB_STARTUP_CONTROL_REG        = 8'h12;
  localparam logic [7:0] SUB_STATUS      = 8'h02;
  localparam logic [7:0] SUB_CLEAR_ALERT = 8'h21;
  localparam logic [7:0] SUB_TABLE [NUM_CMD_REGS] = '{
    8'h07, 8'h10, 8'h12, 8'h20, 8'h23, 8'h24, 8'h25, 8'h26,
    8'h27, 8'h28, 8'h29, 8'h2a, 8'h32, 8'h33};
  localparam logic [7:0] CMD_RESET_VAL   = 8'h00;
  localparam logic [7:0] STATUS_RESET    = 8'h00;
  localparam int BIT_PG_TIMEOUT          = 3;
  localparam int BIT_UV_WARN             = 4;
  localparam int BIT_UV_FAULT            = 5;
  localparam int BIT_THERM_WARN          = 6;
  localparam int BIT_THERM_FAULT         = 7;
  localparam int BIT_SW_CONTROL          = 7;
  localparam int BIT_PG_MASK             = 7;
  localparam int CLK_MHZ                 = 200;
  localparam int INHIBIT_MS              = 1000;
  localparam int PG_TIMEOUT_MS           = 14;
  localparam int INHIBIT_CYCLES          = INHIBIT_MS * 1000 * CLK_MHZ;
  localparam int PG_TIMEOUT_CYCLES       = PG_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int FILTER_CYCLES           = 10;
  typedef enum logic [2:0] {
    BUS_IDLE, BUS_ADDR, BUS_SUB, BUS_DATA, BUS_READ, BUS_IGNORE
  } bus_state_t;
  typedef enum logic [1:0] {PB_ON, PB_POWER_DOWN, PB_POWER_OFF} pb_state_t;
endpackage : pmic_port_pkg

// ===== testbench/i2c_master_model.sv
// bus master model that frames transfers on the serial port
module i2c_master_model #(
  parameter int Q = 16
) (
  // clock and device pin
  input  wire logic clk,
  input  wire logic sda_oe,
  input  wire logic sda_out,
  // bus lines
  output logic      scl,
  output logic      sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sda_drv = 1'b1;
  initial scl = 1'b1;
  // pull-up: a released line reads high
  assign sda = sda_drv & ~(sda_oe & ~sda_out);
  task automatic q();
    repeat (Q) @(negedge clk);
  endtask
  // also serves as repeated start when scl is low
  task automatic start();
    sda_drv = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_drv = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop();
    sda_drv = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_drv = 1'b1;
    q();
  endtask
  // ninth slot always released: ack from device, or nack on reads
  task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      sda_drv = (i == 0) ? 1'b1 : d[i-1];
      q();
      scl = 1'b1;
      q();
      if (i > 0) r[i-1] = sda;
      else ack = ~sda;
      q();
      scl = 1'b0;
      q();
    end
  endtask
endmodule // i2c_master_model

// ===== testbench/pmic_fault_status_serial_port_test.sv
// self-checking bench for the power-management serial control port
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module pmic_fault_status_serial_port_test;
  import pmic_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int INH = 50;
  localparam int PGC = 20;
  int         failures = 0;
  int         checks = 0;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       uv_warn_in = 1'b0;
  logic       uv_fault_in = 1'b0;
  logic       therm_warn_in = 1'b0;
  logic       therm_fault_in = 1'b0;
  logic       power_good_in = 1'b1;
  logic       power_on_request = 1'b1;
  logic [6:0] enable_pins = 7'h00;
  logic       scl, sda, sda_out, sda_oe, alert_n, system_wake_out, ak;
  logic [6:0] regulator_enable;
  logic [7:0] fault_event_status, rd_v, d;
  logic [1:0] pb_state;
  initial forever #2.5 clk = ~clk;
  pmic_fault_status_serial_port #(.INHIBIT_CNT(INH), .PG_CNT(PGC)) uut (
    .clk, .reset_n, .clk_en(1'b1), .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
    .uv_warn_in, .uv_fault_in, .therm_warn_in, .therm_fault_in, .power_good_in,
    .power_on_request, .enable_pins, .alert_n, .system_wake_out, .regulator_enable,
    .fault_event_status, .pb_state);
  i2c_master_model #(.Q(16)) m (.clk, .sda_oe, .sda_out, .scl, .sda);
  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] s, input logic [7:0] v, input logic stp);
    logic a1, a2, a3;
    m.start();
    m.xfer(8'h68, rd_v, a1);
    m.xfer(s, rd_v, a2);
    m.xfer(v, rd_v, a3);
    `CHK("write acks", 1'b1, a1 & a2 & a3)
    if (stp) m.stop();
  endtask
  // a read leaves the bus without a stop
  task automatic rd(input logic sub, input logic [7:0] s);
    logic a1, a2, a3, nk;
    a1 = 1'b1;
    a2 = 1'b1;
    if (sub) begin
      m.start();
      m.xfer(8'h68, rd_v, a1);
      m.xfer(s, rd_v, a2);
    end
    m.start();
    m.xfer(8'h69, rd_v, a3);
    m.xfer(8'hff, rd_v, nk);
    `CHK("read acks", 1'b1, a1 & a2 & a3)
  endtask
  task automatic clr();
    wr(SUB_CLEAR_ALERT, 8'h00, 1'b1);
    repeat (INH + 20) @(negedge clk);
  endtask
  function automatic logic [7:0] fbit(input int k);
    return (k == 0) ? 8'h20 : (k == 1) ? 8'h80 : 8'h08;
  endfunction
  initial begin
    void'($urandom(89));
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("status reset", STATUS_RESET, fault_event_status)
    d = 8'($urandom) & 8'hfc;
    if (d == 8'h68) d = 8'h6c;
    m.start();
    m.xfer(d, rd_v, ak);
    `CHK("foreign addr", 1'b0, ak)
    m.xfer(SUB_REGULATOR_ENABLE_REG, rd_v, ak);
    `CHK("ignored byte", 1'b0, ak)
    m.stop();
    d = 8'($urandom) | 8'h80;
    wr(SUB_REGULATOR_ENABLE_REG, d, 1'b0);
    rd(1'b1, SUB_REGULATOR_ENABLE_REG);
    `CHK("held data", d, rd_v)
    rd(1'b0, SUB_REGULATOR_ENABLE_REG);
    `CHK("polled data", d, rd_v)
    `CHK("uncommitted", 7'h00, regulator_enable)
    m.stop();
    enable_pins = 7'($urandom);
    repeat (30) @(negedge clk);
    `CHK("sw enables", d[6:0], regulator_enable)
    d = 8'($urandom) & 8'h7f;
    wr(SUB_REGULATOR_ENABLE_REG, d, 1'b1);
    repeat (30) @(negedge clk);
    `CHK("or enables", d[6:0] | enable_pins, regulator_enable)
    for (int k = 0; k < 2; k++) begin
      {therm_warn_in, uv_warn_in} = 2'b01 << k;
      repeat (40) @(negedge clk);
      `CHK("warn alert", 1'b0, alert_n)
      rd(1'b1, SUB_STATUS);
      `CHK("warn bit", 8'h10 << (2 * k), rd_v)
      clr();
      `CHK("warn held", 1'b0, alert_n)
      {therm_warn_in, uv_warn_in} = 2'b00;
      clr();
      `CHK("warn cleared", 1'b1, alert_n)
      `CHK("warn bit gone", 8'h00, fault_event_status)
    end
    for (int k = 0; k < 3; k++) begin
      wr(SUB_REGULATOR_ENABLE_REG, 8'h80 | 8'($urandom), 1'b1);
      case (k)
        0: uv_fault_in = 1'b1;
        1: therm_fault_in = 1'b1;
        default: power_good_in = 1'b0;
      endcase
      // pg fault fires only after its timeout, still inside power down
      repeat ((k == 2) ? PGC + 30 : 30) @(negedge clk);
      `CHK("fault alert", 1'b0, alert_n)
      `CHK("fault bit", fbit(k), fault_event_status)
      `CHK("fault enables", 7'h00, regulator_enable)
      `CHK("fault wake", 1'b0, system_wake_out)
      `CHK("fault pb", PB_POWER_DOWN, pb_state)
      {uv_fault_in, therm_fault_in, power_good_in} = 3'b001;
      repeat (INH + 20) @(negedge clk);
      `CHK("fault held", 1'b0, alert_n)
      `CHK("wake back", 1'b1, system_wake_out)
      clr();
      `CHK("fault cleared", 1'b1, alert_n)
      `CHK("fault bit gone", 8'h00, fault_event_status)
    end
    wr(SUB_REGULATOR_ENABLE_REG, 8'hff, 1'b1);
    uv_warn_in = 1'b1;
    repeat (40) @(negedge clk);
    reset_n = 1'b0;
    repeat (3) @(negedge clk);
    `CHK("lockout alert", 1'b1, alert_n)
    `CHK("lockout status", STATUS_RESET, fault_event_status)
    `CHK("lockout enables", 7'h00, regulator_enable)
    `CHK("lockout pb", PB_POWER_OFF, pb_state)
    results();
  end
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    results();
  end
endmodule // pmic_fault_status_serial_port_test
